// ==== core_config_regs.svh ====
// register offsets, field positions, reset values and codes of the core configuration block
`ifndef CORE_CONFIG_REGS_SVH
`define CORE_CONFIG_REGS_SVH

`define SLAVE_CORE_CONFIG_OFFSET      12'h141
`define CORE_FEATURE_CONFIG_LO_OFFSET 12'h142
`define CORE_FEATURE_CONFIG_HI_OFFSET 12'h143
`define RESERVED_CONFIG_LO_OFFSET     12'h144
`define RESERVED_CONFIG_HI_OFFSET     12'h145
`define INTERFACE_CONFIG_OFFSET       12'h150

`define SLAVE_CORE_CONFIG_RESET       8'h00
`define CORE_FEATURE_CONFIG_RESET     16'h0000
`define RESERVED_CONFIG_RESET         16'h0000
`define INTERFACE_CONFIG_RESET        8'h00
`define APPLICATION_LAYER_STATUS_RESET 8'h01

`define SCC_LINK_PORT2_BIT            6
`define SCC_LINK_PORT1_BIT            5
`define SCC_LINK_PORT0_BIT            4
`define SCC_LINK_BITS_MASK            8'h72
`define SCC_USED_MASK                 8'h7F
`define CFC_USED_MASK                 16'hC0C0

`define DIGITAL_IO_PERSONALITY        8'h04

`define SAMPLE_END_OF_FRAME           2'h0
`define SAMPLE_LATCH_EDGE             2'h1
`define SAMPLE_SYNC_ZERO              2'h2
`define SAMPLE_SYNC_ONE               2'h3

`define DIO_WIDTH                     32

`endif

// ==== core_config_pkg.sv ====
// types of the core configuration block
package core_config_pkg;

  typedef struct packed {
    logic       reserved7;
    logic [2:0] link_port_enable;
    logic       latch_unit_enable;
    logic       sync_unit_enable;
    logic       link_all_ports;
    logic       device_emulation;
  } slave_core_config_type;

  typedef struct packed {
    logic [1:0] output_sample_select;
    logic [1:0] input_sample_select;
    logic       watchdog_behaviour;
    logic       bidirectional_mode;
    logic       output_valid_mode;
    logic       output_valid_polarity;
  } dio_config_type;

  typedef struct packed {
    logic       load_strobe;
    logic       load_ok;
    logic [7:0] slave_core_config;
    logic [15:0] core_feature_config;
    logic [15:0] reserved_config_word;
    logic [7:0] interface_config;
  } eeprom_load_type;

  typedef struct packed {
    logic        start_of_frame;
    logic        end_of_frame;
    logic        sync_event_zero;
    logic        sync_event_one;
    logic        watchdog_trigger;
    logic        watchdog_expired;
  } dio_events_type;

  typedef enum logic [1:0] {
    out_running,
    out_pending_reset,
    out_cleared
  } output_state_type;

endpackage

// ==== rising_edge_sync.sv ====
// two-flop synchroniser with rising edge detector
`timescale 1ns/100ps
module rising_edge_sync (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      level,
  output logic      rise
);
  logic stage_one;
  logic stage_two;
  logic stage_three;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      stage_one   <= 1'b0;
      stage_two   <= 1'b0;
      stage_three <= 1'b0;
    end else begin
      stage_one   <= async_in;
      stage_two   <= stage_one;
      stage_three <= stage_two;
    end
  end

  assign level = stage_two;
  assign rise  = stage_two & ~stage_three;
endmodule // rising_edge_sync

// ==== core_config_bank.sv ====
// slave core configuration registers and digital i/o personality
`timescale 1ns/100ps
`include "core_config_regs.svh"

// Summary of operation
// - each per-port link bit enables enhanced link detection on its port
// - all-ports bit enables enhanced link detection on every port
// - clock latch and sync unit bits are readable and do nothing
// - emulation off: status written by interface; on: status follows control
// - slave core configuration comes only from the eeprom load
// - link enable bits latched only at the first load after each reset, and only if that load is good
// - management link detection bit reports phy link detection active
// - error indicator enable bit gates the error indicator output
// - phy register 9 management writes allowed only when enable bit set
// - combined state indicator mode follows its select bit
// - multi-byte registers are little endian: low byte at low address
// - interface configuration meaning depends on personality select
// - outputs update at end of frame, sync zero or sync one; at watchdog trigger when output-valid mode is 1
// - inputs captured at start of frame, latch edge, sync zero or one
// - watchdog expiry clears outputs at once or at next output event
// - direction mode: per-pin directions or all pins bidirectional
// - output-valid signals output events or watchdog triggers
// - output-valid polarity: 0 active high, 1 active low
// - digital i/o personality applies for select code 04h
// - status writable from interface only while emulation off
module core_config_bank (
  input  wire logic                            sys_clk,
  input  wire logic                            resetn,
  input  core_config_pkg::eeprom_load_type     eeprom_load,
  input  wire logic [7:0]                      interface_personality_select,
  input  wire logic [11:0]                     read_addr,
  output logic [7:0]                           read_data,
  input  wire logic                            status_write,
  input  wire logic [7:0]                      status_write_data,
  input  wire logic                            control_write,
  input  wire logic [7:0]                      control_write_data,
  output logic [7:0]                           application_layer_status,
  output logic [2:0]                           enhanced_link_enable,
  output logic                                 phy_link_detection_active,
  input  wire logic                            error_indicator_request,
  output logic                                 error_indicator,
  input  wire logic                            phy_reg9_write_request,
  output logic                                 phy_reg9_write_allowed,
  output logic                                 combined_state_indicator,
  input  core_config_pkg::dio_events_type      dio_events,
  input  wire logic                            latch_input,
  input  wire logic [`DIO_WIDTH-1:0]           pending_output_data,
  input  wire logic [`DIO_WIDTH-1:0]           direction_control,
  input  wire logic [`DIO_WIDTH-1:0]           dio_pin_in,
  output logic [`DIO_WIDTH-1:0]                dio_pin_out,
  output logic [`DIO_WIDTH-1:0]                dio_pin_oe,
  output logic [`DIO_WIDTH-1:0]                captured_inputs,
  output logic                                 output_valid
);
  import core_config_pkg::*;

  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  slave_core_config_type slave_core_config;
  slave_core_config_type next_slave_core_config;
  logic [15:0]           core_feature_config;
  logic [15:0]           next_core_feature_config;
  logic [15:0]           reserved_config_word;
  logic [15:0]           next_reserved_config_word;
  dio_config_type        interface_config;
  dio_config_type        next_interface_config;
  logic                  link_captured;
  logic                  next_link_captured;
  logic [7:0]            next_application_layer_status;
  logic                  digital_io_active;

  always_comb begin
    next_slave_core_config    = slave_core_config;
    next_core_feature_config  = core_feature_config;
    next_reserved_config_word = reserved_config_word;
    next_interface_config     = interface_config;
    next_link_captured        = link_captured;
    if (eeprom_load.load_strobe) begin
      // loaded only from the eeprom, no write path
      next_slave_core_config.latch_unit_enable = eeprom_load.slave_core_config[3];
      next_slave_core_config.sync_unit_enable  = eeprom_load.slave_core_config[2];
      next_slave_core_config.device_emulation  = eeprom_load.slave_core_config[0];
      next_core_feature_config  = eeprom_load.core_feature_config & `CFC_USED_MASK;
      next_reserved_config_word = eeprom_load.reserved_config_word;
      next_interface_config     = eeprom_load.interface_config;
      // link bits only at the first load, and only if it is good
      if (!link_captured) begin
        next_link_captured = 1'b1;
        if (eeprom_load.load_ok) begin
          next_slave_core_config.link_port_enable = eeprom_load.slave_core_config[6:4];
          next_slave_core_config.link_all_ports   = eeprom_load.slave_core_config[1];
        end
      end
    end
    next_slave_core_config.reserved7 = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      slave_core_config    <= `SLAVE_CORE_CONFIG_RESET;
      core_feature_config  <= `CORE_FEATURE_CONFIG_RESET;
      reserved_config_word <= `RESERVED_CONFIG_RESET;
      interface_config     <= `INTERFACE_CONFIG_RESET;
      link_captured        <= 1'b0;
    end else begin
      slave_core_config    <= next_slave_core_config;
      core_feature_config  <= next_core_feature_config;
      reserved_config_word <= next_reserved_config_word;
      interface_config     <= next_interface_config;
      link_captured        <= next_link_captured;
    end
  end

  // ------------------------------------------------------------
  // feature outputs
  // ------------------------------------------------------------
  assign enhanced_link_enable = slave_core_config.link_port_enable
                              | {3{slave_core_config.link_all_ports}};
  assign phy_link_detection_active = core_feature_config[15];
  assign error_indicator = error_indicator_request & core_feature_config[14];
  assign phy_reg9_write_allowed = phy_reg9_write_request & core_feature_config[7];
  assign combined_state_indicator = core_feature_config[6];
  assign digital_io_active = (interface_personality_select == `DIGITAL_IO_PERSONALITY);

  // ------------------------------------------------------------
  // application layer status
  // ------------------------------------------------------------
  always_comb begin
    next_application_layer_status = application_layer_status;
    if (slave_core_config.device_emulation) begin
      if (control_write) begin
        next_application_layer_status = control_write_data;
      end
    end else if (status_write) begin
      next_application_layer_status = status_write_data;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      application_layer_status <= `APPLICATION_LAYER_STATUS_RESET;
    end else begin
      application_layer_status <= next_application_layer_status;
    end
  end

  // ------------------------------------------------------------
  // register read port, little endian
  // ------------------------------------------------------------
  logic [7:0] next_read_data;

  always_comb begin
    case (read_addr)
      `SLAVE_CORE_CONFIG_OFFSET:      next_read_data = slave_core_config & `SCC_USED_MASK;
      `CORE_FEATURE_CONFIG_LO_OFFSET: next_read_data = core_feature_config[7:0];
      `CORE_FEATURE_CONFIG_HI_OFFSET: next_read_data = core_feature_config[15:8];
      `RESERVED_CONFIG_LO_OFFSET:     next_read_data = reserved_config_word[7:0];
      `RESERVED_CONFIG_HI_OFFSET:     next_read_data = reserved_config_word[15:8];
      `INTERFACE_CONFIG_OFFSET:       next_read_data = interface_config;
      default:                        next_read_data = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      read_data <= 8'h00;
    end else begin
      read_data <= next_read_data;
    end
  end

  // ------------------------------------------------------------
  // latch input synchroniser
  // ------------------------------------------------------------
  logic latch_rise;

  rising_edge_sync latch_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (latch_input),
    .level    (),
    .rise     (latch_rise)
  );

  // ------------------------------------------------------------
  // digital i/o events
  // ------------------------------------------------------------
  logic output_event;
  logic input_event;

  always_comb begin
    output_event = 1'b0;
    if (interface_config.output_valid_mode) begin
      output_event = dio_events.watchdog_trigger;
    end else begin
      case (interface_config.output_sample_select)
        `SAMPLE_END_OF_FRAME: output_event = dio_events.end_of_frame;
        `SAMPLE_SYNC_ZERO:    output_event = dio_events.sync_event_zero;
        `SAMPLE_SYNC_ONE:     output_event = dio_events.sync_event_one;
        default:              output_event = 1'b0;
      endcase
    end
    output_event = output_event & digital_io_active;
  end

  always_comb begin
    case (interface_config.input_sample_select)
      `SAMPLE_END_OF_FRAME: input_event = dio_events.start_of_frame;
      `SAMPLE_LATCH_EDGE:   input_event = latch_rise;
      `SAMPLE_SYNC_ZERO:    input_event = dio_events.sync_event_zero;
      `SAMPLE_SYNC_ONE:     input_event = dio_events.sync_event_one;
      default:              input_event = 1'b0;
    endcase
    input_event = input_event & digital_io_active;
  end

  // ------------------------------------------------------------
  // input pins
  // ------------------------------------------------------------
  logic [`DIO_WIDTH-1:0] pin_stage_one;
  logic [`DIO_WIDTH-1:0] pin_stage_two;
  logic [`DIO_WIDTH-1:0] next_captured_inputs;

  always_comb begin
    next_captured_inputs = captured_inputs;
    if (input_event) begin
      next_captured_inputs = pin_stage_two;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_stage_one   <= '0;
      pin_stage_two   <= '0;
      captured_inputs <= '0;
    end else begin
      pin_stage_one   <= dio_pin_in;
      pin_stage_two   <= pin_stage_one;
      captured_inputs <= next_captured_inputs;
    end
  end

  // ------------------------------------------------------------
  // output pins and watchdog reaction
  // ------------------------------------------------------------
  output_state_type      out_state;
  output_state_type      next_out_state;
  logic [`DIO_WIDTH-1:0] next_dio_pin_out;
  logic                  valid_active;
  logic                  next_valid_active;

  always_comb begin
    next_out_state    = out_state;
    next_dio_pin_out  = dio_pin_out;
    next_valid_active = output_event;
    case (out_state)
      out_running: begin
        if (dio_events.watchdog_expired && !interface_config.watchdog_behaviour) begin
          next_dio_pin_out = '0;
          next_out_state   = out_cleared;
        end else if (dio_events.watchdog_expired) begin
          next_out_state = out_pending_reset;
          if (output_event) begin
            next_dio_pin_out = pending_output_data;
          end
        end else if (output_event) begin
          next_dio_pin_out = pending_output_data;
        end
      end
      out_pending_reset: begin
        if (output_event) begin
          next_dio_pin_out = '0;
          next_out_state   = out_cleared;
        end
      end
      out_cleared: begin
        if (dio_events.watchdog_trigger) begin
          next_out_state = out_running;
          if (output_event) begin
            next_dio_pin_out = pending_output_data;
          end
        end
      end
      default: begin
        next_out_state = out_running;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      out_state    <= out_running;
      dio_pin_out  <= '0;
      valid_active <= 1'b0;
    end else begin
      out_state    <= next_out_state;
      dio_pin_out  <= next_dio_pin_out;
      valid_active <= next_valid_active;
    end
  end

  assign output_valid = valid_active ^ interface_config.output_valid_polarity;

  // per-pin direction, or all pins released as bidirectional inputs
  assign dio_pin_oe = (!digital_io_active || interface_config.bidirectional_mode)
                    ? '0 : ~direction_control;

endmodule // core_config_bank

// ==== core_config_bank_asserts.sv ====
// port assertions of the core configuration bank
`timescale 1ns/100ps
module core_config_bank_asserts (
  input wire logic                        sys_clk,
  input wire logic                        resetn,
  input core_config_pkg::eeprom_load_type eeprom_load,
  input wire logic [7:0]                  interface_personality_select,
  input wire logic [11:0]                 read_addr,
  input wire logic [7:0]                  read_data,
  input wire logic                        status_write,
  input wire logic                        control_write,
  input wire logic [7:0]                  application_layer_status,
  input wire logic [2:0]                  enhanced_link_enable,
  input wire logic                        error_indicator_request,
  input wire logic                        error_indicator,
  input wire logic                        phy_reg9_write_request,
  input wire logic                        phy_reg9_write_allowed,
  input core_config_pkg::dio_events_type  dio_events,
  input wire logic [31:0]                 direction_control,
  input wire logic [31:0]                 dio_pin_out,
  input wire logic [31:0]                 dio_pin_oe
);
  import core_config_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // --------------------
  // port relations
  // --------------------
  property p_err_gate; error_indicator |-> error_indicator_request; endproperty
  a_err_gate: assert property (p_err_gate) else $error("error indicator without request");
  property p_reg9_gate; phy_reg9_write_allowed |-> phy_reg9_write_request; endproperty
  a_reg9_gate: assert property (p_reg9_gate) else $error("reg9 write allowed without request");
  property p_status_init; $rose(resetn) |-> application_layer_status == 8'h01; endproperty
  a_status_init: assert property (p_status_init) else $error("status not init after reset");
  property p_status_cause; $changed(application_layer_status) |-> $past(status_write) || $past(control_write);
  endproperty
  a_status_cause: assert property (p_status_cause) else $error("status changed without write");
  property p_link_hold;
    $changed(enhanced_link_enable) |-> $past(eeprom_load.load_strobe) || $past(eeprom_load.load_strobe, 2);
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link enables changed without load");
  property p_out_cause; $changed(dio_pin_out) |-> $past(|dio_events[4:0]); endproperty
  a_out_cause: assert property (p_out_cause) else $error("outputs changed without event");
  property p_oe_dir;
    |dio_pin_oe |-> interface_personality_select == 8'h04 && dio_pin_oe == ~direction_control;
  endproperty
  a_oe_dir: assert property (p_oe_dir) else $error("output enables wrong");
  property p_unmapped;
    !(read_addr inside {12'h141, 12'h142, 12'h143, 12'h144, 12'h145, 12'h150}) |=> read_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // core_config_bank_asserts

// ==== config_eeprom_model.sv ====
// configuration eeprom model feeding loads into the core configuration bank
`timescale 1ns/100ps
module config_eeprom_model (
  input wire logic                         sys_clk,
  output core_config_pkg::eeprom_load_type eeprom_load
);
  import core_config_pkg::*;
  // --------------------
  // load sequence
  // --------------------
  initial eeprom_load = '0;
  task automatic load(input logic ok, input logic [7:0] scc, input logic [15:0] feat, input logic [7:0] ifc);
    @(negedge sys_clk);
    eeprom_load = {1'b1, ok, scc, feat, 16'h5A3C, ifc};
    @(negedge sys_clk);
    eeprom_load = {1'b0, ~eeprom_load[48:0]};
    @(negedge sys_clk);
  endtask
endmodule // config_eeprom_model

// ==== tb_core_config_bank.sv ====
// self-checking testbench of the core configuration bank
`timescale 1ns/100ps
module tb_core_config_bank;
  import core_config_pkg::*;
  logic            sys_clk, resetn, status_write, control_write, latch_input, output_valid;
  logic            error_indicator_request, phy_reg9_write_request, phy_link_detection_active;
  logic            error_indicator, phy_reg9_write_allowed, combined_state_indicator;
  logic [2:0]      enhanced_link_enable;
  logic [7:0]      interface_personality_select, read_data, status_write_data, control_write_data;
  logic [7:0]      application_layer_status;
  logic [11:0]     read_addr;
  logic [31:0]     pending_output_data, direction_control, dio_pin_in, dio_pin_out, dio_pin_oe;
  logic [31:0]     captured_inputs;
  eeprom_load_type eeprom_load;
  dio_events_type  dio_events;
  int              miscompares, cmp_count;
  logic [11:0]     addrs [6] = '{12'h141, 12'h142, 12'h143, 12'h144, 12'h145, 12'h150};
  logic [7:0]      image [6] = '{8'h5D, 8'hC0, 8'hC0, 8'h3C, 8'h5A, 8'h81};
  logic [5:0]      ev_out [3] = '{6'h10, 6'h08, 6'h04};
  logic [5:0]      ev_in [4] = '{6'h20, 6'h00, 6'h08, 6'h04};
  logic [1:0]      codes [3] = '{2'h0, 2'h2, 2'h3};
  wire [3:0]       feat_outs = {phy_link_detection_active, error_indicator, phy_reg9_write_allowed,
                                combined_state_indicator};
  core_config_bank i_dut (.*);
  config_eeprom_model i_eeprom (.sys_clk(sys_clk), .eeprom_load(eeprom_load));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // --------------------
  // access tasks
  // --------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] addr, input logic [7:0] exp);
    tick(1);
    read_addr = addr;
    tick(1);
    chk("read_data", 32'(exp), 32'(read_data));
  endtask
  task automatic wr(input logic ctl, input logic [7:0] d);
    tick(1);
    {control_write, status_write, control_write_data, status_write_data} = {ctl, !ctl, d, d};
    tick(1);
    {control_write, status_write} = 2'b00;
  endtask
  task automatic ev(input logic [5:0] e);
    tick(1);
    dio_events = e;
    tick(1);
    dio_events = '0;
  endtask
  task automatic rst();
    tick(1);
    resetn = 1'b0;
    tick(2);
    resetn = 1'b1;
  endtask
  task automatic cfg(input logic [7:0] ifc);
    i_eeprom.load(1'b1, 8'h01, 16'h0000, ifc);
  endtask
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // --------------------
  // tests
  // --------------------
  initial begin
    {resetn, status_write, control_write, latch_input, status_write_data, control_write_data} = '0;
    {error_indicator_request, phy_reg9_write_request, read_addr, dio_events} = {2'b11, 12'h000, 6'h00};
    {interface_personality_select, pending_output_data} = {8'h04, 32'h0000_0000};
    {direction_control, dio_pin_in} = {32'h0000_FFFF, 32'h1234_5678};
    tick(12);
    resetn = 1'b1;
    foreach (addrs[k]) rd(addrs[k], 8'h00);
    chk("status", 32'h01, 32'(application_layer_status));
    i_eeprom.load(1'b1, 8'hDD, 16'hFFFF, 8'h81);
    foreach (addrs[k]) rd(addrs[k], image[k]);
    chk("link", 32'h5, 32'(enhanced_link_enable));
    chk("features", 32'hF, 32'(feat_outs));
    chk("valid idle", 32'h1, 32'(output_valid));
    error_indicator_request = 1'b0;
    tick(1);
    chk("error_indicator", 32'h0, 32'(error_indicator));
    error_indicator_request = 1'b1;
    wr(1'b0, 8'h04);
    chk("status", 32'h01, 32'(application_layer_status));
    wr(1'b1, 8'h08);
    chk("status", 32'h08, 32'(application_layer_status));
    i_eeprom.load(1'b1, 8'h22, 16'h4080, 8'h00);
    rd(12'h141, 8'h50);
    rd(12'h142, 8'h80);
    rd(12'h143, 8'h40);
    chk("link", 32'h5, 32'(enhanced_link_enable));
    chk("features", 32'h6, 32'(feat_outs));
    wr(1'b1, 8'h0C);
    chk("status", 32'h08, 32'(application_layer_status));
    wr(1'b0, 8'h02);
    chk("status", 32'h02, 32'(application_layer_status));
    rd(12'h146, 8'h00);
    rst();
    i_eeprom.load(1'b1, 8'h02, 16'h0000, 8'h00);
    chk("link", 32'h7, 32'(enhanced_link_enable));
    rst();
    i_eeprom.load(1'b0, 8'h72, 16'h0000, 8'h00);
    i_eeprom.load(1'b1, 8'h72, 16'h0000, 8'h00);
    chk("link", 32'h0, 32'(enhanced_link_enable));
    cfg(8'h40);
    ev(6'h10);
    chk("pins", 32'h0, dio_pin_out);
    for (int i = 0; i < 3; i++) begin
      cfg({codes[i], 6'h00});
      pending_output_data = {8{4'(i + 1)}};
      ev(ev_out[i]);
      chk("pins", pending_output_data, dio_pin_out);
      chk("valid", 32'h1, 32'(output_valid));
      tick(1);
      chk("valid", 32'h0, 32'(output_valid));
    end
    cfg(8'h03);
    pending_output_data = 32'hCAFE_0001;
    ev(6'h10);
    chk("pins", 32'h3333_3333, dio_pin_out);
    ev(6'h02);
    chk("pins", 32'hCAFE_0001, dio_pin_out);
    chk("valid", 32'h0, 32'(output_valid));
    for (int j = 0; j < 4; j++) begin
      cfg({2'h0, 2'(j), 4'h0});
      dio_pin_in = {28'h0F0F000, 4'(j)};
      tick(3);
      if (j == 1) begin
        latch_input = 1'b1;
        tick(6);
        latch_input = 1'b0;
      end else begin
        ev(ev_in[j]);
      end
      chk("captured", dio_pin_in, captured_inputs);
    end
    chk("oe", ~direction_control, dio_pin_oe);
    cfg(8'h04);
    chk("oe", 32'h0, dio_pin_oe);
    interface_personality_select = 8'h80;
    cfg(8'h00);
    chk("oe", 32'h0, dio_pin_oe);
    pending_output_data = 32'h0000_5555;
    ev(6'h10);
    chk("pins", 32'hCAFE_0001, dio_pin_out);
    interface_personality_select = 8'h04;
    ev(6'h10);
    chk("pins", 32'h0000_5555, dio_pin_out);
    ev(6'h01);
    chk("pins", 32'h0, dio_pin_out);
    cfg(8'h08);
    ev(6'h02);
    ev(6'h10);
    chk("pins", 32'h0000_5555, dio_pin_out);
    ev(6'h01);
    chk("pins", 32'h0000_5555, dio_pin_out);
    ev(6'h10);
    chk("pins", 32'h0, dio_pin_out);
    print_verdict();
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict();
  end
endmodule // tb_core_config_bank

bind core_config_bank core_config_bank_asserts i_chk (.*);
